// ===== hdl/fsp_pkg.sv
// package of the flash self-program controller: indices, resets, codes,
// field positions, timings and carrier structs.
// assumes a 125 MHz clock and 32-bit AXI4-Lite data.
package fsp_pkg;

    // clock and bus geometry
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int AXI_ADDR_W = 12;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_ADDR_HIGH = 8'hce;
    localparam logic [7:0] IDX_ADDR_LOW = 8'hcf;
    localparam logic [7:0] IDX_WRITE_BYTE = 8'hd1;
    localparam logic [7:0] IDX_COMMAND = 8'hd2;
    localparam logic [7:0] IDX_TIMING = 8'hd3;
    localparam logic [7:0] IDX_READ_BYTE = 8'hd4;
    localparam logic [7:0] IDX_STATUS = 8'he0;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_TIMING = 8'hdd;

    // command codes and mode sequences
    localparam logic [7:0] CMD_ERASE = 8'h96;
    localparam logic [7:0] CMD_BURN = 8'h69;
    localparam logic [7:0] CMD_READ = 8'h88;
    localparam int SEQ_LEN = 5;
    localparam logic [0:SEQ_LEN-1][7:0] ENTER_SEQ = {8'h12, 8'h34, 8'h56, 8'h78, 8'h9a};
    localparam logic [0:SEQ_LEN-1][7:0] EXIT_SEQ = {8'hfe, 8'hdc, 8'hba, 8'h98, 8'h76};
    localparam logic [1:0] BOOT_SEL_LOCKED = 2'h3;

    // address-high field layout
    localparam int BLK_MSB = 7;
    localparam int BLK_LSB = 6;
    localparam int DSEL_MSB = 6;
    localparam int DSEL_LSB = 2;
    localparam int PAGE_BIT = 2;
    localparam int DOFS_MSB = 1;
    localparam int DOFS_LSB = 0;
    localparam int IOFS_BIT = 0;
    localparam int TIM_MSB = 4;
    localparam logic [1:0] BLK_NONE = 2'h0;
    localparam logic [1:0] BLK_INFO = 2'h1;
    localparam logic [1:0] BLK_SYS = 2'h2;
    localparam logic [4:0] DSEL_DATA = 5'h00;
    localparam logic [15:0] DATA_BASE = 16'hfc00;
    localparam logic [4:0] TIM_LINEAR_MAX = 5'h09;

    // status register bits
    localparam int ST_BUSY = 0;
    localparam int ST_BOOT = 1;
    localparam int ST_ERR = 2;

    // operation times and their cycle counts
    localparam int unsigned BURN_NS = 23500;
    localparam int unsigned ERASE_BASE_NS = 1130000;
    localparam int unsigned ERASE_STEP_NS = 1000000;
    localparam int unsigned ERASE_CAP_NS = 9130000;
    localparam int unsigned BURN_CYC = (BURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned READ_WAIT_CYC = 2;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_ERASE = 2'h1,
        OP_BURN = 2'h2,
        OP_READ = 2'h3
    } fsp_op_t;

    typedef enum logic [2:0] {
        AREA_DATA = 3'h0,
        AREA_INFO3 = 3'h1,
        AREA_INFO4 = 3'h2,
        AREA_SYS = 3'h3,
        AREA_CODE = 3'h4
    } fsp_area_t;

    typedef struct packed {
        logic valid;
        fsp_area_t area;
        logic [15:0] addr;
    } fsp_target_t;

    typedef struct packed {
        logic start;
        fsp_op_t op;
        fsp_area_t area;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fsp_flash_req_t;

    typedef struct packed {
        logic awvalid;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_ADDR_W-1:0] araddr;
        logic rready;
    } fsp_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fsp_axi_rsp_t;

endpackage : fsp_pkg

// ===== hdl/fsp_op_timer.sv
// loadable down-counter that times one flash operation.
// assumes load values of at least one; load wins over counting.
`timescale 1ns/1ps
module fsp_op_timer
#(
    parameter int CNT_W = 24
)
(
    input logic clk, // system clock
    input logic rst, // asynchronous reset, active high
    input logic load, // one-cycle pulse that starts a count
    input logic [CNT_W-1:0] load_cnt, // cycles to run
    output logic done, // one-cycle pulse when the count runs out
    output logic running // count in progress
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic done;
    } fsp_tmr_state_t;

    fsp_tmr_state_t s_q;
    fsp_tmr_state_t s_d;

    // next state: count down, flag the last step
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (load)
        begin
            s_d.cnt = load_cnt;
        end
        else if (s_q.cnt != '0)
        begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
            s_d.done = (s_q.cnt == CNT_W'(1));
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign running = (s_q.cnt != '0);

endmodule : fsp_op_timer

// ===== hdl/fsp_flash_ctrl.sv
// flash self-program controller: register file on AXI4-Lite, boot-upgrade
// mode sequences, address decode and timed erase, burn and indirect read.
// assumes the flash array sits on the same clock and that the boot strap
// inputs come from same-clock logic.
// Operation
// - read: high bits 7:6 select system/info block
// - data area only when high bits 6:2 zero
// - data offset is high 1:0 over low byte
// - high bit 2 picks page four, else three
// - boot mode: high and low form full address
// - low address register, read/write, resets to zero
// - command 96 erase, 69 burn, 88 read
// - five-byte sequence enters boot-upgrade mode
// - five-byte sequence leaves boot-upgrade mode
// - entry refused when locked or outside boot
// - byte burn lasts a fixed 23.5 us
// - data erase 1.13 ms plus field, capped
// - indirect read result lands in read register
`timescale 1ns/1ps
module fsp_flash_ctrl
    import fsp_pkg::*;
#(
    parameter int CNT_W = 24,
    parameter int unsigned ERASE_BASE_CYC = ERASE_BASE_NS / CLK_PERIOD_NS,
    parameter int unsigned ERASE_STEP_CYC = ERASE_STEP_NS / CLK_PERIOD_NS,
    parameter int unsigned ERASE_CAP_CYC = ERASE_CAP_NS / CLK_PERIOD_NS,
    parameter int unsigned INFO_BASE_CYC = ERASE_BASE_NS / CLK_PERIOD_NS,
    parameter int unsigned INFO_STEP_CYC = ERASE_STEP_NS / CLK_PERIOD_NS,
    parameter int unsigned INFO_CAP_CYC = ERASE_CAP_NS / CLK_PERIOD_NS,
    parameter logic [4:0] INFO_LINEAR_MAX = TIM_LINEAR_MAX
)
(
    input logic clk, // system clock
    input logic rst, // asynchronous reset, active high
    input fsp_axi_req_t axi_req, // AXI4-Lite master side
    output fsp_axi_rsp_t axi_rsp, // AXI4-Lite slave side
    input logic [1:0] boot_area_cfg, // boot-area configuration value
    input logic exec_in_boot, // processor fetching from boot space
    output fsp_flash_req_t flash_req, // request to the flash array
    input logic [7:0] flash_rdata, // byte from the flash array
    output logic flash_busy // an operation is running
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_FINISH = 2'b11
    } fsp_fsm_t;

    typedef struct packed {
        fsp_fsm_t fsm;
        logic aw_got;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] addr_high;
        logic [7:0] addr_low;
        logic [7:0] write_byte;
        logic [7:0] command;
        logic [7:0] timing;
        logic [7:0] read_byte;
        logic boot_mode;
        logic err;
        logic [2:0] enter_pos;
        logic [2:0] exit_pos;
        fsp_op_t op;
        fsp_area_t area;
        logic [15:0] faddr;
        logic [7:0] fdata;
        logic start;
    } fsp_state_t;

    fsp_state_t s_q;
    fsp_state_t s_d;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_cnt;
    logic tmr_done;

    // map a command byte onto an operation
    function automatic fsp_op_t cmd_op(input logic [7:0] b);
        fsp_op_t o;
        o = OP_NONE;
        if (b == CMD_ERASE)
        begin
            o = OP_ERASE;
        end
        else if (b == CMD_BURN)
        begin
            o = OP_BURN;
        end
        else if (b == CMD_READ)
        begin
            o = OP_READ;
        end
        return o;
    endfunction : cmd_op

    // advance a sequence matcher; a stray byte restarts it
    function automatic logic [2:0] seq_step(
        input logic [2:0] pos,
        input logic [7:0] b,
        input logic [0:SEQ_LEN-1][7:0] seq
    );
        logic [2:0] p;
        p = 3'h0;
        if (b == seq[pos])
        begin
            p = pos + 3'h1;
        end
        else if (b == seq[0])
        begin
            p = 3'h1;
        end
        return p;
    endfunction : seq_step

    // turn the two address registers into an area and an array address
    function automatic fsp_target_t decode(
        input fsp_op_t op,
        input logic [7:0] h,
        input logic [7:0] l,
        input logic boot
    );
        fsp_target_t t;
        t.valid = 1'b1;
        t.area = AREA_CODE;
        t.addr = {h, l};
        if (op == OP_READ)
        begin
            if (h[BLK_MSB:BLK_LSB] == BLK_SYS)
            begin
                t.area = AREA_SYS;
                t.addr = {6'h00, h[DOFS_MSB:DOFS_LSB], l};
            end
            else if (h[BLK_MSB:BLK_LSB] == BLK_INFO)
            begin
                t.area = h[PAGE_BIT] ? AREA_INFO4 : AREA_INFO3;
                t.addr = {7'h00, h[IOFS_BIT], l};
            end
            else
            begin
                t.valid = 1'b0;
            end
        end
        else if (!boot)
        begin
            if (h[BLK_MSB:BLK_LSB] == BLK_NONE && h[DSEL_MSB:DSEL_LSB] == DSEL_DATA)
            begin
                t.area = AREA_DATA;
                t.addr = DATA_BASE | {6'h00, h[DOFS_MSB:DOFS_LSB], l};
            end
            else if (h[BLK_MSB:BLK_LSB] == BLK_INFO)
            begin
                t.area = h[PAGE_BIT] ? AREA_INFO4 : AREA_INFO3;
                t.addr = {7'h00, h[IOFS_BIT], l};
            end
            else
            begin
                t.valid = 1'b0;
            end
        end
        return t;
    endfunction : decode

    // cycles that an operation holds the array
    function automatic logic [CNT_W-1:0] duration(
        input fsp_op_t op,
        input fsp_area_t area,
        input logic [4:0] f
    );
        logic [CNT_W-1:0] c;
        c = CNT_W'(READ_WAIT_CYC);
        if (op == OP_BURN)
        begin
            c = CNT_W'(BURN_CYC);
        end
        else if (op == OP_ERASE && area == AREA_DATA)
        begin
            c = (f <= TIM_LINEAR_MAX) ? CNT_W'(ERASE_BASE_CYC + f * ERASE_STEP_CYC)
                                      : CNT_W'(ERASE_CAP_CYC);
        end
        else if (op == OP_ERASE)
        begin
            c = (f <= INFO_LINEAR_MAX) ? CNT_W'(INFO_BASE_CYC + f * INFO_STEP_CYC)
                                       : CNT_W'(INFO_CAP_CYC);
        end
        return c;
    endfunction : duration

    // next state: bus, registers, sequences, operations
    always_comb
    begin
        logic [7:0] widx;
        logic [7:0] ridx;
        logic wmap;
        logic rmap;
        logic [7:0] b;
        logic [2:0] ep;
        logic [2:0] xp;
        fsp_op_t op;
        fsp_target_t tgt;
        widx = s_q.aw_addr[IDX_MSB:IDX_LSB];
        ridx = axi_req.araddr[IDX_MSB:IDX_LSB];
        wmap = (s_q.aw_addr[AXI_ADDR_W-1:IDX_MSB+1] == '0);
        rmap = (axi_req.araddr[AXI_ADDR_W-1:IDX_MSB+1] == '0);
        b = s_q.w_data;
        ep = 3'h0;
        xp = 3'h0;
        op = OP_NONE;
        tgt = '0;
        tmr_load = 1'b0;
        tmr_cnt = '0;
        s_d = s_q;
        s_d.start = 1'b0;

        // address and data taken apart, either order
        if (axi_req.awvalid && axi_rsp.awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready)
        begin
            s_d.w_got = 1'b1;
            s_d.w_data = axi_req.wdata[7:0];
            s_d.w_lane = axi_req.wstrb[0];
        end
        if (s_q.bvalid && axi_req.bready)
        begin
            s_d.bvalid = 1'b0;
        end

        // perform the write once both halves are held
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            if (!wmap)
            begin
                s_d.bresp = RESP_SLVERR;
            end
            else if (widx == IDX_ADDR_HIGH)
            begin
                s_d.addr_high = s_q.w_lane ? b : s_q.addr_high;
            end
            else if (widx == IDX_ADDR_LOW)
            begin
                s_d.addr_low = s_q.w_lane ? b : s_q.addr_low;
            end
            else if (widx == IDX_WRITE_BYTE)
            begin
                s_d.write_byte = s_q.w_lane ? b : s_q.write_byte;
            end
            else if (widx == IDX_TIMING)
            begin
                s_d.timing = s_q.w_lane ? b : s_q.timing;
            end
            else if (widx == IDX_STATUS)
            begin
                // error flag is write-one-to-clear
                s_d.err = s_q.err & ~(s_q.w_lane & b[ST_ERR]);
            end
            else if (widx == IDX_COMMAND)
            begin
                // busy: whole write dropped, sequences too
                if (s_q.w_lane && s_q.fsm == ST_IDLE)
                begin
                    s_d.command = b;
                    ep = seq_step(s_q.enter_pos, b, ENTER_SEQ);
                    xp = seq_step(s_q.exit_pos, b, EXIT_SEQ);
                    s_d.enter_pos = ep;
                    s_d.exit_pos = xp;
                    if (ep == 3'(SEQ_LEN))
                    begin
                        s_d.enter_pos = 3'h0;
                        if (boot_area_cfg != BOOT_SEL_LOCKED && exec_in_boot)
                        begin
                            s_d.boot_mode = 1'b1;
                        end
                    end
                    if (xp == 3'(SEQ_LEN))
                    begin
                        s_d.exit_pos = 3'h0;
                        s_d.boot_mode = 1'b0;
                    end
                    op = cmd_op(b);
                    tgt = decode(op, s_q.addr_high, s_q.addr_low, s_q.boot_mode);
                    if (op != OP_NONE && tgt.valid)
                    begin
                        s_d.op = op;
                        s_d.area = tgt.area;
                        s_d.faddr = tgt.addr;
                        s_d.fdata = s_q.write_byte;
                        s_d.start = 1'b1;
                        s_d.fsm = ST_RUN;
                        tmr_load = 1'b1;
                        tmr_cnt = duration(op, tgt.area, s_q.timing[TIM_MSB:0]);
                    end
                    else if (op != OP_NONE)
                    begin
                        s_d.err = 1'b1; // invalid target, nothing started
                    end
                end
            end
            else
            begin
                s_d.bresp = RESP_SLVERR; // read-only or unmapped
            end
        end

        // read channel: one outstanding read, answered the next cycle
        if (s_q.rvalid && axi_req.rready)
        begin
            s_d.rvalid = 1'b0;
        end
        if (axi_req.arvalid && axi_rsp.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = 8'h00;
            if (!rmap)
            begin
                s_d.rresp = RESP_SLVERR;
            end
            else if (ridx == IDX_ADDR_HIGH)
            begin
                s_d.rdata = s_q.addr_high;
            end
            else if (ridx == IDX_ADDR_LOW)
            begin
                s_d.rdata = s_q.addr_low;
            end
            else if (ridx == IDX_WRITE_BYTE)
            begin
                s_d.rdata = s_q.write_byte;
            end
            else if (ridx == IDX_COMMAND)
            begin
                s_d.rdata = s_q.command;
            end
            else if (ridx == IDX_TIMING)
            begin
                s_d.rdata = s_q.timing;
            end
            else if (ridx == IDX_READ_BYTE)
            begin
                s_d.rdata = s_q.read_byte;
            end
            else if (ridx == IDX_STATUS)
            begin
                s_d.rdata[ST_BUSY] = (s_q.fsm != ST_IDLE);
                s_d.rdata[ST_BOOT] = s_q.boot_mode;
                s_d.rdata[ST_ERR] = s_q.err;
            end
            else
            begin
                s_d.rresp = RESP_SLVERR;
            end
        end

        // operation sequencer
        unique case (s_q.fsm)
            ST_IDLE:
            begin
            end
            ST_RUN:
            begin
                if (tmr_done)
                begin
                    s_d.fsm = ST_FINISH;
                end
            end
            ST_FINISH:
            begin
                if (s_q.op == OP_READ)
                begin
                    s_d.read_byte = flash_rdata;
                end
                s_d.fsm = ST_IDLE;
            end
            default:
            begin
                s_d.fsm = ST_IDLE; // illegal code recovers
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.addr_high <= RST_BYTE;
            s_q.addr_low <= RST_BYTE;
            s_q.write_byte <= RST_BYTE;
            s_q.command <= RST_BYTE;
            s_q.timing <= RST_TIMING;
            s_q.read_byte <= RST_BYTE;
            s_q.fsm <= ST_IDLE;
            s_q.op <= OP_NONE;
            s_q.area <= AREA_DATA;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // one timer serves all ops; only one runs at a time
    fsp_op_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .load(tmr_load),
        .load_cnt(tmr_cnt),
        .done(tmr_done),
        .running()
    );

    // bus handshakes are combinational, payloads come from flops
    assign axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
    assign axi_rsp.wready = !s_q.w_got && !s_q.bvalid;
    assign axi_rsp.bvalid = s_q.bvalid;
    assign axi_rsp.bresp = s_q.bresp;
    assign axi_rsp.arready = !s_q.rvalid;
    assign axi_rsp.rvalid = s_q.rvalid;
    assign axi_rsp.rdata = {24'h000000, s_q.rdata};
    assign axi_rsp.rresp = s_q.rresp;

    // flash array request
    assign flash_req.start = s_q.start;
    assign flash_req.op = s_q.op;
    assign flash_req.area = s_q.area;
    assign flash_req.addr = s_q.faddr;
    assign flash_req.wdata = s_q.fdata;
    assign flash_busy = (s_q.fsm != ST_IDLE);

endmodule : fsp_flash_ctrl

// ===== verification/fsp_flash_ctrl_properties.sv
// checker for the flash self-program controller: bus answers and op lengths.
// assumes only the ports of the controller; bound in at the foot.
`timescale 1ns/1ps
module fsp_props
    import fsp_pkg::*;
(
    input logic clk, // system clock
    input logic rst, // async reset, active high
    input fsp_axi_req_t axi_req, // bus requests
    input fsp_axi_rsp_t axi_rsp, // bus answers
    input logic [1:0] boot_area_cfg, // boot-area setting
    input logic exec_in_boot, // fetching from boot space
    input fsp_flash_req_t flash_req, // array request
    input logic [7:0] flash_rdata, // array byte
    input logic flash_busy // op running
);
    int unsigned len_q; // busy cycles, start cycle included
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // op lengths are counted: too long to unroll
    always_ff @(posedge clk or posedge rst)
        if (rst) len_q <= 0;
        else if (flash_req.start) len_q <= 1;
        else if (flash_busy) len_q <= len_q + 1;
    start_pulse_a: assert property (flash_req.start |=> !flash_req.start)
        else $error("start pulse too long");
    start_busy_a: assert property (flash_req.start |-> flash_busy)
        else $error("start without busy");
    no_restart_a: assert property (flash_busy && $past(flash_busy) |-> !flash_req.start)
        else $error("start while busy");
    burn_len_a: assert property ($fell(flash_busy) && flash_req.op == OP_BURN |->
        len_q == BURN_CYC + 2) else $error("burn length");
    read_len_a: assert property ($fell(flash_busy) && flash_req.op == OP_READ |->
        len_q == READ_WAIT_CYC + 2) else $error("read length");
    data_addr_a: assert property (flash_req.start && flash_req.area == AREA_DATA
        |-> flash_req.addr[15:10] == 6'h3f) else $error("data base");
    read_area_a: assert property (flash_req.start && flash_req.op == OP_READ
        |-> flash_req.area inside {AREA_INFO3, AREA_INFO4, AREA_SYS}) else $error("read area");
    b_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready |-> ##2 axi_rsp.bvalid) else $error("late write answer");
    r_answer_a: assert property (axi_req.arvalid && axi_rsp.arready
        |=> axi_rsp.rvalid && axi_rsp.rdata[31:8] == 24'h0) else $error("bad read answer");
    r_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data moved");
    cover property (flash_req.start && flash_req.op == OP_BURN);
    cover property (flash_req.start && flash_req.op == OP_READ);
    cover property (flash_req.start && flash_req.area == AREA_CODE);
endmodule : fsp_props
bind fsp_flash_ctrl fsp_props u_props (.clk(clk), .rst(rst), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .boot_area_cfg(boot_area_cfg), .exec_in_boot(exec_in_boot),
    .flash_req(flash_req), .flash_rdata(flash_rdata), .flash_busy(flash_busy));

// ===== verification/fsp_flash_ctrl_tb.sv
// self-checking bench for the flash controller, driven over AXI4-Lite.
// assumes shortened erase counts; checker bound in separately.
`timescale 1ns/1ps
module fsp_flash_ctrl_tb;
    import fsp_pkg::*;
    localparam int EB = 20, ES = 10, EC = 100;
    logic clk = 1'b0;
    logic rst = 1'b1;
    fsp_axi_req_t rq = '0;
    fsp_axi_rsp_t rs;
    logic [1:0] cfg = 2'h0;
    logic exe = 1'b0;
    fsp_flash_req_t fr;
    fsp_flash_req_t got;
    logic [7:0] frd = 8'h00;
    logic busy;
    int err_count = 0;
    int samples_checked = 0;
    int seed = 84004;
    int busy_n = 0, n_start = 0;
    int fl[4] = '{0, 9, 10, 31};
    logic [1:0] resp;
    logic [7:0] h, l, d;
    fsp_flash_ctrl #(.ERASE_BASE_CYC(EB), .ERASE_STEP_CYC(ES), .ERASE_CAP_CYC(EC),
        .INFO_BASE_CYC(EB), .INFO_STEP_CYC(ES), .INFO_CAP_CYC(EC)) dut (.clk(clk),
        .rst(rst), .axi_req(rq), .axi_rsp(rs), .boot_area_cfg(cfg), .exec_in_boot(exe),
        .flash_req(fr), .flash_rdata(frd), .flash_busy(busy));
    initial forever #4 clk = ~clk;
    // falling-edge samples see settled outputs
    always @(negedge clk)
    begin
        if (busy === 1'b1) busy_n++;
        if (fr.start === 1'b1)
        begin
            n_start++;
            got = fr;
        end
    end
    task automatic chk(logic [31:0] g, logic [31:0] e, string what);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, g, e);
        end
    endtask : chk
    // one write; each channel drops once taken
    task automatic wr(logic [7:0] idx, logic [7:0] v, logic [1:0] er);
        logic a, w, b;
        @(posedge clk);
        rq.awaddr <= {2'h0, idx, 2'h0};
        rq.wdata <= {24'h0, v};
        rq.wstrb <= 4'h1;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        b = 1'b0;
        while (b !== 1'b1)
        begin
            @(negedge clk);
            a = rq.awvalid && rs.awready;
            w = rq.wvalid && rs.wready;
            b = rs.bvalid && rq.bready;
            resp = rs.bresp;
            @(posedge clk);
            if (a) rq.awvalid <= 1'b0;
            if (w) rq.wvalid <= 1'b0;
        end
        rq.bready <= 1'b0;
        chk(resp, er, "bresp");
    endtask : wr
    task automatic rdr(logic [7:0] idx, logic [31:0] e, logic [1:0] er, string what);
        logic a, b;
        logic [31:0] v;
        @(posedge clk);
        rq.araddr <= {2'h0, idx, 2'h0};
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        b = 1'b0;
        while (b !== 1'b1)
        begin
            @(negedge clk);
            a = rq.arvalid && rs.arready;
            b = rs.rvalid && rq.rready;
            v = rs.rdata;
            resp = rs.rresp;
            @(posedge clk);
            if (a) rq.arvalid <= 1'b0;
        end
        rq.rready <= 1'b0;
        chk(v, e, what);
        chk(resp, er, "rresp");
    endtask : rdr
    function automatic int elen(int fv);
        return (fv <= 9 ? EB + fv * ES : EC) + 2;
    endfunction : elen
    // command, optional second write of the erase command while busy, timed
    task automatic run(logic [7:0] cmd, int len, bit dup);
        busy_n = 0;
        n_start = 0;
        wr(IDX_COMMAND, cmd, RESP_OKAY);
        if (dup) wr(IDX_COMMAND, CMD_ERASE, RESP_OKAY);
        for (int t = 0; t < 5000 && busy !== 1'b0; t++) @(negedge clk);
        chk(busy_n, len, "busy length");
        chk(n_start, len > 0, "start count");
    endtask : run
    task automatic tgt(logic [7:0] hv, logic [7:0] cmd, int len, fsp_area_t ar,
        logic [15:0] ad);
        wr(IDX_ADDR_HIGH, hv, RESP_OKAY);
        run(cmd, len, 0);
        chk(got.area, ar, "area");
        chk(got.addr, ad, "addr");
    endtask : tgt
    task automatic seq(logic [0:SEQ_LEN-1][7:0] s);
        foreach (s[i]) wr(IDX_COMMAND, s[i], RESP_OKAY);
    endtask : seq
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdr(IDX_ADDR_LOW, 0, RESP_OKAY, "low");
        rdr(IDX_TIMING, 32'hdd, RESP_OKAY, "timing");
        rdr(IDX_READ_BYTE, 0, RESP_OKAY, "rbyte");
        rdr(8'h10, 0, RESP_SLVERR, "unmapped");
        wr(IDX_READ_BYTE, 8'h55, RESP_SLVERR);
        $display("test registers done");
        h = $random(seed) & 8'h03;
        l = $random(seed);
        d = $random(seed);
        wr(IDX_ADDR_LOW, l, RESP_OKAY);
        wr(IDX_WRITE_BYTE, d, RESP_OKAY);
        rdr(IDX_ADDR_LOW, {24'h0, l}, RESP_OKAY, "low");
        wr(IDX_ADDR_HIGH, h, RESP_OKAY);
        run(CMD_BURN, BURN_CYC + 2, 1);
        chk(got.addr, {6'h3f, h[1:0], l}, "addr");
        chk(got.wdata, d, "wdata");
        foreach (fl[i])
        begin
            wr(IDX_TIMING, {3'h7, fl[i][4:0]}, RESP_OKAY);
            tgt(h, CMD_ERASE, elen(fl[i]), AREA_DATA, {6'h3f, h[1:0], l});
        end
        run(CMD_BURN, BURN_CYC + 2, 0);
        $display("test data area done");
        wr(IDX_ADDR_HIGH, 8'h04, RESP_OKAY);
        run(CMD_ERASE, 0, 0);
        rdr(IDX_STATUS, 32'h4, RESP_OKAY, "err");
        wr(IDX_STATUS, 8'h04, RESP_OKAY);
        tgt(8'h45, CMD_ERASE, elen(31), AREA_INFO4, {7'h0, 1'b1, l});
        frd <= $random(seed);
        tgt(8'h41, CMD_READ, READ_WAIT_CYC + 2, AREA_INFO3, {7'h0, 1'b1, l});
        rdr(IDX_READ_BYTE, {24'h0, frd}, RESP_OKAY, "rbyte");
        frd <= $random(seed);
        tgt(8'h82, CMD_READ, READ_WAIT_CYC + 2, AREA_SYS, {6'h0, 2'h2, l});
        rdr(IDX_READ_BYTE, {24'h0, frd}, RESP_OKAY, "rbyte");
        $display("test targets done");
        seq(ENTER_SEQ);
        rdr(IDX_STATUS, 0, RESP_OKAY, "boot");
        cfg <= BOOT_SEL_LOCKED;
        exe <= 1'b1;
        seq(ENTER_SEQ);
        rdr(IDX_STATUS, 0, RESP_OKAY, "boot");
        cfg <= 2'h1;
        seq(ENTER_SEQ);
        rdr(IDX_STATUS, 32'h2, RESP_OKAY, "boot");
        h = $random(seed);
        tgt(h, CMD_BURN, BURN_CYC + 2, AREA_CODE, {h, l});
        seq(EXIT_SEQ);
        rdr(IDX_STATUS, 0, RESP_OKAY, "boot");
        $display("test boot mode done");
        tally_and_finish();
    end
endmodule : fsp_flash_ctrl_tb
